// ### verilog/mut_regs.svh
// Register offsets, field positions, reset values and counts of the timer.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
`ifndef MUT_REGS_SVH
`define MUT_REGS_SVH

`define MUT_ADDR_CTRL      8'h00
`define MUT_ADDR_CNT_LO    8'h04
`define MUT_ADDR_CNT_HI    8'h08
`define MUT_ADDR_STATUS    8'h0C
`define MUT_ADDR_MASK      8'h10

`define MUT_CTRL_RUN       0
`define MUT_CTRL_MODE_LO   1
`define MUT_CTRL_SUB       3
`define MUT_CTRL_CLK_LP    4
`define MUT_CTRL_PRE_LO    5
`define MUT_CTRL_EVT       7
`define MUT_CTRL_SHOT_LO   8

`define MUT_ST_OVF_LO      0
`define MUT_ST_OVF_HI      1

`define MUT_RST_COUNT      8'h00
`define MUT_RST_FLAGS      2'h0

`define MUT_PRE_MAX_DIV2   3'h1
`define MUT_PRE_MAX_DIV4   3'h3
`define MUT_PRE_MAX_DIV8   3'h7
`define MUT_M0_PRE_MAX     5'h1F
`define MUT_BYTE_MAX       8'hFF

`define MUT_SYNC_FAST      0
`define MUT_SYNC_LP        1
`define MUT_SYNC_CNT       2
`define MUT_SYNC_TRG       3
`define MUT_SYNC_MEAS      4

`endif

// ### verilog/mut_pkg.sv
// Types of the multimode up timer: modes, single-shot states, state record.
// Assumes the constants header is included by the timer module.
package mut_pkg;

	typedef enum logic [1:0] {
		MUT_MODE_13BIT  = 2'h0,
		MUT_MODE_16BIT  = 2'h1,
		MUT_MODE_RELOAD = 2'h2,
		MUT_MODE_SPLIT  = 2'h3
	} mut_mode_e;

	// Gray coded along idle, armed, running.
	typedef enum logic [1:0] {
		MUT_SHOT_IDLE  = 2'h0,
		MUT_SHOT_ARMED = 2'h1,
		MUT_SHOT_RUN   = 2'h3
	} mut_shot_e;

	typedef struct packed {
		logic [4:0]  sync1;
		logic [4:0]  sync2;
		logic [4:0]  syncd;
		logic [2:0]  presc;
		logic [7:0]  lo;
		logic [7:0]  hi;
		logic        run;
		mut_mode_e   mode;
		logic        sub;
		logic        clk_lp;
		logic [1:0]  pre_sel;
		logic        evt;
		mut_shot_e   shot;
		logic [1:0]  status;
		logic [1:0]  mask;
		logic        meas_start;
		logic        irq;
		logic        ack;
		logic [31:0] dat;
	} mut_state_s;

endpackage : mut_pkg

// ### verilog/mut_timer.sv
// Multimode 16-bit up timer with a classic Wishbone register port.
// Assumes clk_i at 20 MHz; all pin inputs are asynchronous to clk_i.
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "mut_regs.svh"

module mut_timer
	import mut_pkg::*;
#(
	parameter int unsigned AW = 8
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          cyc_i,
	input  wire logic          stb_i,
	input  wire logic          we_i,
	input  wire logic [AW-1:0] adr_i,
	input  wire logic [3:0]    sel_i,
	input  wire logic [31:0]   dat_i,
	output logic               ack_o,
	output logic      [31:0]   dat_o,
	input  wire logic          fast_internal_clock_i,
	input  wire logic          low_power_clock_i,
	input  wire logic          count_pin_i,
	input  wire logic          trigger_i,
	input  wire logic          measured_slow_clock_i,
	output logic               meas_start_o,
	output logic               irq_o
);

	mut_state_s r;
	mut_state_s n;
	logic [4:0] rise;
	logic [4:0] fall;
	logic       src_edge;
	logic       pre_tick;
	logic       tick;
	logic       active;
	logic       ovf_lo;
	logic       ovf_hi;
	logic       req;
	logic       wr;
	logic [2:0] pre_max;
	logic [31:0] rd;

	// Refuse, while the design is built, address widths that cannot
	// hold the register map or that exceed a 32-bit bus address.
	if (AW < 5 || AW > 32) begin : g_bad_aw
		$error("mut_timer: AW must be 5 to 32");
	end

	// Edges seen on the synchronised pins.
	assign rise = r.sync2 & ~r.syncd;
	assign fall = ~r.sync2 & r.syncd;
	assign req = cyc_i & stb_i;
	// A write lands on the edge at which the master sees ack high.
	assign wr = req & we_i & r.ack & sel_i[0];

	// Read data multiplexer; unmapped addresses read zero.
	always_comb begin
		rd = 32'h0000_0000;
		case (adr_i)
			AW'(`MUT_ADDR_CTRL): begin
				rd[`MUT_CTRL_RUN] = r.run;
				rd[`MUT_CTRL_MODE_LO +: 2] = r.mode;
				rd[`MUT_CTRL_SUB] = r.sub;
				rd[`MUT_CTRL_CLK_LP] = r.clk_lp;
				rd[`MUT_CTRL_PRE_LO +: 2] = r.pre_sel;
				rd[`MUT_CTRL_EVT] = r.evt;
				rd[`MUT_CTRL_SHOT_LO +: 2] = r.shot;
			end
			AW'(`MUT_ADDR_CNT_LO): rd[7:0] = r.lo;
			AW'(`MUT_ADDR_CNT_HI): rd[7:0] = r.hi;
			AW'(`MUT_ADDR_STATUS): rd[1:0] = r.status;
			AW'(`MUT_ADDR_MASK):   rd[1:0] = r.mask;
			default: rd = 32'h0000_0000;
		endcase
	end

	// Next state of the whole timer.
	always_comb begin
		n = r;
		src_edge = 1'b0;
		pre_tick = 1'b0;
		tick = 1'b0;
		ovf_lo = 1'b0;
		ovf_hi = 1'b0;
		n.sync1 = {measured_slow_clock_i, trigger_i, count_pin_i,
			low_power_clock_i, fast_internal_clock_i};
		n.sync2 = r.sync1;
		n.syncd = r.sync2;
		n.meas_start = 1'b0;

		src_edge = r.clk_lp ? rise[`MUT_SYNC_LP] : rise[`MUT_SYNC_FAST];

		// Prescaler by 2, 4 or 8.
		case (r.pre_sel)
			2'h0:    pre_max = `MUT_PRE_MAX_DIV2;
			2'h1:    pre_max = `MUT_PRE_MAX_DIV4;
			default: pre_max = `MUT_PRE_MAX_DIV8;
		endcase
		// The prescaler is held at zero while stopped, so the first tick
		// after a start always takes a full division.
		if (!r.run) begin
			n.presc = 3'h0;
		end else if (src_edge) begin
			if (r.presc >= pre_max) begin
				n.presc = 3'h0;
				pre_tick = 1'b1;
			end else begin
				n.presc = 3'(r.presc + 3'h1);
			end
		end

		tick = r.evt ? fall[`MUT_SYNC_CNT] : pre_tick;

		case (r.shot)
			MUT_SHOT_IDLE: begin
				if (r.run && r.mode == MUT_MODE_16BIT && r.sub) begin
					n.shot = MUT_SHOT_ARMED;
				end
			end
			MUT_SHOT_ARMED: begin
				if (!r.run) begin
					n.shot = MUT_SHOT_IDLE;
				end else if (rise[`MUT_SYNC_TRG]) begin
					n.shot = MUT_SHOT_RUN;
					n.meas_start = 1'b1;
				end
			end
			MUT_SHOT_RUN: begin
				if (!r.run) begin
					n.shot = MUT_SHOT_IDLE;
				end
			end
			default: n.shot = MUT_SHOT_IDLE;
		endcase
		active = r.run && !(r.mode == MUT_MODE_16BIT && r.sub &&
			r.shot != MUT_SHOT_RUN);

		if (active) begin
			case (r.mode)
				MUT_MODE_13BIT: begin
					// Five-bit prescaler under an 8-bit count.
					if (tick) begin
						if (r.lo[4:0] == `MUT_M0_PRE_MAX) begin
							n.lo[4:0] = 5'h00;
							n.hi = 8'(r.hi + 8'h01);
							ovf_hi = (r.hi == `MUT_BYTE_MAX);
						end else begin
							n.lo[4:0] = 5'(r.lo[4:0] + 5'h01);
						end
					end
				end
				MUT_MODE_16BIT: begin
					if (tick) begin
						{n.hi, n.lo} = 16'({r.hi, r.lo} + 16'h0001);
						ovf_hi = ({r.hi, r.lo} == 16'hFFFF);
						if (ovf_hi && r.sub) begin
							n.run = 1'b0;
							n.shot = MUT_SHOT_IDLE;
						end
					end
				end
				MUT_MODE_RELOAD: begin
					// Reload low byte from high byte.
					if (tick) begin
						if (r.lo == `MUT_BYTE_MAX) begin
							n.lo = r.hi;
							ovf_lo = 1'b1;
						end else begin
							n.lo = 8'(r.lo + 8'h01);
						end
					end
				end
				default: begin
					// Independent bytes on the same tick.
					// Submode b counts slow clock edges low.
					if (r.sub ? rise[`MUT_SYNC_MEAS] : tick) begin
						n.lo = 8'(r.lo + 8'h01);
						ovf_lo = (r.lo == `MUT_BYTE_MAX);
					end
					if (tick) begin
						n.hi = 8'(r.hi + 8'h01);
						ovf_hi = (r.hi == `MUT_BYTE_MAX);
					end
				end
			endcase
		end

		// Software writes take precedence over counting.
		if (wr) begin
			case (adr_i)
				AW'(`MUT_ADDR_CTRL): begin
					n.run = dat_i[`MUT_CTRL_RUN];
					// Restart the prescaler, so a smaller divider
					// never meets a count past its new end.
					n.presc = 3'h0;
					n.mode = mut_mode_e'(dat_i[`MUT_CTRL_MODE_LO +: 2]);
					n.sub = dat_i[`MUT_CTRL_SUB];
					n.clk_lp = dat_i[`MUT_CTRL_CLK_LP];
					n.pre_sel = dat_i[`MUT_CTRL_PRE_LO +: 2];
					n.evt = dat_i[`MUT_CTRL_EVT];
				end
				AW'(`MUT_ADDR_CNT_LO): n.lo = dat_i[7:0];
				AW'(`MUT_ADDR_CNT_HI): n.hi = dat_i[7:0];
				AW'(`MUT_ADDR_MASK):   n.mask = dat_i[1:0];
				default: n.mask = r.mask;
			endcase
		end

		// Clearing is applied first and the overflow sets after it, so an
		// event in the clearing cycle is never lost.
		// Sticky flags; a new overflow beats a clear.
		// Low and high overflows go to their own flags.
		if (wr && adr_i == AW'(`MUT_ADDR_STATUS)) begin
			n.status = r.status & ~dat_i[1:0];
		end
		n.status[`MUT_ST_OVF_LO] = n.status[`MUT_ST_OVF_LO] | ovf_lo;
		n.status[`MUT_ST_OVF_HI] = n.status[`MUT_ST_OVF_HI] | ovf_hi;
		n.irq = |(n.status & n.mask);

		// Single-cycle ack, one clock after the request.
		// Ack low in the previous cycle guards against a second ack while
		// the master still holds its request.
		n.ack = req & ~r.ack;
		n.dat = n.ack ? rd : 32'h0000_0000;
	end

	// State register.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '{
				shot:   MUT_SHOT_IDLE,
				mode:   MUT_MODE_13BIT,
				lo:     `MUT_RST_COUNT,
				hi:     `MUT_RST_COUNT,
				status: `MUT_RST_FLAGS,
				mask:   `MUT_RST_FLAGS,
				default: '0
			};
		end else begin
			r <= n;
		end
	end

	// Outputs come straight from the state register.
	assign ack_o = r.ack;
	assign dat_o = r.dat;
	assign meas_start_o = r.meas_start;
	assign irq_o = r.irq;

	// Checks on the system clock, silent while reset is high.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Bus answer: one ack pulse per request; a write needs the low lane.
	a_ack_single: assert property (req && !ack_o |=> ack_o ##1 !ack_o)
		else $error("ack not a single pulse after request");
	a_sel_guard: assert property (req && we_i && !sel_i[0] &&
		adr_i == AW'(`MUT_ADDR_MASK) |=> $stable(r.mask))
		else $error("write without low lane changed the mask");

	// Flags: set by their own overflow, cleared by a one, seen by irq.
	a_irq_level: assert property (
		irq_o == |(r.status & r.mask))
		else $error("irq does not follow unmasked flags");
	a_lo_flag_set: assert property (
		ovf_lo |=> r.status[`MUT_ST_OVF_LO])
		else $error("low overflow flag not set");
	a_hi_flag_set: assert property (
		ovf_hi |=> r.status[`MUT_ST_OVF_HI])
		else $error("high overflow flag not set");
	a_hi_flag_own: assert property (
		!r.status[`MUT_ST_OVF_HI] && !ovf_hi |=>
		!r.status[`MUT_ST_OVF_HI])
		else $error("high flag set without high overflow");
	a_flag_clear: assert property (
		wr && adr_i == AW'(`MUT_ADDR_STATUS) && dat_i[`MUT_ST_OVF_LO]
		&& !ovf_lo |=> !r.status[`MUT_ST_OVF_LO])
		else $error("low flag not cleared by a one");

	// Timing tick: selected source and division.
	a_clk_sel: assert property (
		r.run && !wr &&
		!(r.clk_lp ? rise[`MUT_SYNC_LP] : rise[`MUT_SYNC_FAST])
		|=> $stable(r.presc))
		else $error("prescaler moved without a selected edge");
	a_presc_div: assert property (
		!r.evt && pre_tick |-> src_edge && r.presc == pre_max)
		else $error("prescaler tick at wrong count");
	a_event_edge: assert property (
		r.evt && r.run |-> (tick == fall[`MUT_SYNC_CNT]))
		else $error("event tick not on falling edge");

	// Counting per mode.
	a_chain_hold: assert property (
		active && r.mode == MUT_MODE_16BIT && !tick && !wr
		|=> $stable({r.hi, r.lo}))
		else $error("16-bit count moved without a tick");
	a_m0_hold: assert property (
		active && r.mode == MUT_MODE_13BIT && tick &&
		r.lo[4:0] != `MUT_M0_PRE_MAX && !wr |=> $stable(r.hi))
		else $error("13-bit high part moved early");
	a_m0_upper: assert property (
		active && r.mode == MUT_MODE_13BIT && !wr
		|=> $stable(r.lo[7:5]))
		else $error("13-bit count touched upper low bits");
	a_chain_up: assert property (
		active && r.mode == MUT_MODE_16BIT && tick && !wr
		|=> {r.hi, r.lo} == 16'($past({r.hi, r.lo}) + 16'h0001))
		else $error("16-bit count did not step up");

	// Single shot.
	a_shot_start: assert property (
		meas_start_o |-> r.shot == MUT_SHOT_RUN)
		else $error("measurement start outside run");
	a_shot_pulse: assert property (
		meas_start_o |=> !meas_start_o)
		else $error("measurement start longer than one cycle");
	a_shot_stop: assert property (
		active && r.mode == MUT_MODE_16BIT && r.sub && tick && !wr &&
		{r.hi, r.lo} == 16'hFFFF |=> !r.run)
		else $error("single shot did not stop at overflow");

	// Reload.
	a_reload_val: assert property (
		active && r.mode == MUT_MODE_RELOAD && tick &&
		r.lo == `MUT_BYTE_MAX && !wr |=> r.lo == $past(r.hi))
		else $error("low byte not reloaded");
	a_reload_hi: assert property (
		active && r.mode == MUT_MODE_RELOAD && !wr |=> $stable(r.hi))
		else $error("reload value moved while counting");

	// Split bytes.
	a_split_lo: assert property (
		active && r.mode == MUT_MODE_SPLIT && !r.sub && tick && !wr
		|=> r.lo == 8'($past(r.lo) + 8'h01))
		else $error("split low byte did not step");
	a_split_hi: assert property (
		active && r.mode == MUT_MODE_SPLIT && tick && !wr
		|=> r.hi == 8'($past(r.hi) + 8'h01))
		else $error("split high byte did not step");
	a_split_meas: assert property (
		active && r.mode == MUT_MODE_SPLIT && r.sub &&
		!rise[`MUT_SYNC_MEAS] && !wr |=> $stable(r.lo))
		else $error("low byte moved without slow edge");

	c_reload: cover property (ovf_lo && r.mode == MUT_MODE_RELOAD);
	c_chain_ovf: cover property (ovf_hi && r.mode == MUT_MODE_16BIT);
	c_shot: cover property (meas_start_o ##[1:1000] r.shot == MUT_SHOT_IDLE);
	c_irq: cover property ($rose(irq_o));
	c_meas: cover property (r.mode == MUT_MODE_SPLIT && r.sub &&
		rise[`MUT_SYNC_MEAS]);

endmodule : mut_timer

// ### dv/mut_far_side.sv
// Far-side model: timing clocks, count pin, trigger and measured clock.
// Assumes the bench pulses go_i for one cycle and waits while busy_o.
`timescale 1ns/1ps

module mut_far_side (
	input  wire logic       clk_i,
	input  wire logic       go_i,
	input  wire logic [2:0] sel_i,
	input  wire logic [3:0] n_i,
	output logic            busy_o,
	output logic            fast_o,
	output logic            lp_o,
	output logic            cnt_o,
	output logic            trg_o,
	output logic            meas_o
);
	logic [3:0] left_reg = 4'h0;
	logic [2:0] ph_reg   = 3'h0;
	logic       pulse;

	// Counts out n pulses, four cycles high and four low each.
	always_ff @(posedge clk_i) begin
		if (go_i) begin
			left_reg <= n_i;
			ph_reg   <= 3'h0;
		end else if (left_reg != 4'h0) begin
			ph_reg <= ph_reg + 3'h1;
			if (ph_reg == 3'h7)
				left_reg <= left_reg - 4'h1;
		end
	end

	// Lines stand still between bursts, so no stray edge is counted.
	assign pulse  = (left_reg != 4'h0) && !ph_reg[2];
	assign busy_o = go_i || (left_reg != 4'h0);
	assign fast_o = pulse && (sel_i == 3'h0);
	assign lp_o   = pulse && (sel_i == 3'h1);
	assign meas_o = pulse && (sel_i == 3'h3);
	assign trg_o  = pulse && (sel_i == 3'h4);
	assign cnt_o  = !(pulse && (sel_i == 3'h2));
endmodule : mut_far_side

// ### dv/mut_timer_bench.sv
// Self-checking bench of the timer through its Wishbone register port.
// Assumes mut_far_side makes every pin edge the bench asks for.
`timescale 1ns/1ps
`include "mut_regs.svh"

module mut_timer_bench;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0;
	logic        we = 1'b0, go = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0, rdata;
	logic [2:0]  sel = 3'h0;
	logic [3:0]  num = 4'h0;
	logic [3:0]  be = 4'hF;
	wire logic   ack, ms, irq, busy, fck, lck, cnt, trg, meas;
	wire [31:0]  q;
	int fail_count = 0, samples_checked = 0, cycles = 0, starts = 0;

	// Free-running 20 MHz clock.
	always #25 clk_i = ~clk_i;

	mut_timer #(.AW(8)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(be), .dat_i(dat),
		.ack_o(ack), .dat_o(q), .fast_internal_clock_i(fck),
		.low_power_clock_i(lck), .count_pin_i(cnt), .trigger_i(trg),
		.measured_slow_clock_i(meas), .meas_start_o(ms), .irq_o(irq));

	mut_far_side fs (.clk_i(clk_i), .go_i(go), .sel_i(sel), .n_i(num),
		.busy_o(busy), .fast_o(fck), .lp_o(lck), .cnt_o(cnt),
		.trg_o(trg), .meas_o(meas));

	// Counts start pulses and cuts a hung run short.
	always @(posedge clk_i) begin
		cycles++;
		if (ms === 1'b1)
			starts++;
		if (cycles == 20000) begin
			fail_count++;
			stop_test;
		end
	end

	task stop_test;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test

	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	// One classic cycle, held until ack is sampled high.
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rdata = q;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask : wb

	task rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(rdata, e);
	endtask : rd

	task pins(input logic [2:0] s, input logic [3:0] n);
		@(posedge clk_i);
		sel <= s;
		num <= n;
		go  <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		do @(posedge clk_i); while (busy);
		repeat (8) @(posedge clk_i);
	endtask : pins

	function logic [31:0] cw(input logic [1:0] m, input logic s, lp,
		input logic [1:0] p, input logic e);
		return {24'h0, e, p, lp, s, m, 1'b1};
	endfunction : cw

	task setup(input logic [7:0] lo, input logic [7:0] hi,
		input logic [31:0] c);
		wb(1'b1, `MUT_ADDR_CTRL, 32'h0);
		wb(1'b1, `MUT_ADDR_STATUS, 32'h3);
		wb(1'b1, `MUT_ADDR_CNT_LO, {24'h0, lo});
		wb(1'b1, `MUT_ADDR_CNT_HI, {24'h0, hi});
		wb(1'b1, `MUT_ADDR_CTRL, c);
	endtask : setup

	task res(input logic [31:0] lo, input logic [31:0] hi,
		input logic [31:0] st);
		rd(`MUT_ADDR_CNT_LO, lo);
		rd(`MUT_ADDR_CNT_HI, hi);
		rd(`MUT_ADDR_STATUS, st);
	endtask : res

	task t_reset;
		res(32'h0, 32'h0, 32'h0);
		rd(`MUT_ADDR_CTRL, 32'h0);
		rd(`MUT_ADDR_MASK, 32'h0);
		wb(1'b1, 8'h14, 32'hFF);
		rd(8'h14, 32'h0);
		be <= 4'hE;
		wb(1'b1, `MUT_ADDR_MASK, 32'h3);
		be <= 4'hF;
		rd(`MUT_ADDR_MASK, 32'h0);
		wb(1'b1, `MUT_ADDR_CTRL, 32'h3FE);
		rd(`MUT_ADDR_CTRL, 32'hFE);
		$display("test reset done");
	endtask : t_reset

	task t_split;
		setup(8'hFE, 8'hFF, cw(2'h3, 1'b0, 1'b0, 2'h0, 1'b0));
		wb(1'b1, `MUT_ADDR_MASK, 32'h1);
		pins(3'h0, 4'h4);
		res(32'h0, 32'h1, 32'h3);
		chk({31'h0, irq}, 32'h1);
		wb(1'b1, `MUT_ADDR_STATUS, 32'h1);
		rd(`MUT_ADDR_STATUS, 32'h2);
		chk({31'h0, irq}, 32'h0);
		wb(1'b1, `MUT_ADDR_MASK, 32'h2);
		rd(`MUT_ADDR_MASK, 32'h2);
		chk({31'h0, irq}, 32'h1);
		$display("test split done");
	endtask : t_split

	task t_presc;
		for (int p = 0; p < 4; p++) begin
			setup(8'h00, 8'h00, cw(2'h1, 1'b0, 1'b1, p[1:0], 1'b0));
			pins(3'h1, 4'h8);
			rd(`MUT_ADDR_CNT_LO,
				(p == 0) ? 32'h4 : (p == 1) ? 32'h2 : 32'h1);
		end
		$display("test prescaler done");
	endtask : t_presc

	task t_events;
		setup(8'hFE, 8'hFF, cw(2'h1, 1'b0, 1'b0, 2'h0, 1'b1));
		pins(3'h2, 4'h2);
		res(32'h0, 32'h0, 32'h2);
		setup(8'hFE, 8'hFF, cw(2'h0, 1'b0, 1'b0, 2'h0, 1'b1));
		pins(3'h2, 4'h2);
		res(32'hE0, 32'h0, 32'h2);
		setup(8'hFE, 8'h80, cw(2'h2, 1'b0, 1'b0, 2'h0, 1'b1));
		pins(3'h2, 4'h3);
		res(32'h81, 32'h80, 32'h1);
		$display("test events done");
	endtask : t_events

	task t_shot;
		setup(8'hFE, 8'hFF, cw(2'h1, 1'b1, 1'b0, 2'h0, 1'b1));
		pins(3'h2, 4'h1);
		rd(`MUT_ADDR_CNT_LO, 32'hFE);
		rd(`MUT_ADDR_CTRL, 32'h18B);
		pins(3'h4, 4'h1);
		chk(starts, 32'h1);
		pins(3'h2, 4'h2);
		res(32'h0, 32'h0, 32'h2);
		rd(`MUT_ADDR_CTRL, 32'h8A);
		$display("test single shot done");
	endtask : t_shot

	task t_meas;
		setup(8'h00, 8'h00, cw(2'h3, 1'b1, 1'b0, 2'h0, 1'b0));
		pins(3'h3, 4'h3);
		res(32'h3, 32'h0, 32'h0);
		pins(3'h0, 4'h4);
		res(32'h3, 32'h2, 32'h0);
		$display("test measure done");
	endtask : t_meas

	// Main sequence after two reset cycles.
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_split;
		t_presc;
		t_events;
		t_shot;
		t_meas;
		stop_test;
	end
endmodule : mut_timer_bench
